// *** common/dtc_defines.svh ***
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH
// descriptor ram window, lower 16 address bits
`define DTC_RAM_BASE    16'hebc0
`define DTC_RAM_LAST    16'hefbf
// descriptor layout: 8 bytes per vector, word offsets inside one record
`define DTC_REC_BYTES   16'h0008
`define DTC_OFS_MODE    16'h0000
`define DTC_OFS_SRC     16'h0002
`define DTC_OFS_DST     16'h0004
`define DTC_OFS_CNT     16'h0006
// mode descriptor a field positions
`define DTC_SZ_BIT      0
`define DTC_DTS_BIT     1
`define DTC_MD_LSB      2
`define DTC_DM_LSB      4
`define DTC_SM_LSB      6
// mode descriptor b field positions
`define DTC_CHAIN_ENABLE_BIT    7
`define DTC_CHAIN_SELECT_BIT    6
`define DTC_CPU_IRQ_SELECT_BIT   5
// mode codes
`define DTC_MD_NORMAL   2'h0
`define DTC_MD_REPEAT   2'h1
`define DTC_MD_BLOCK    2'h2
`endif

// *** common/dtc_pkg.sv ***
package dtc_pkg;
  // bus request toward memory
  typedef struct packed {
    logic        req;
    logic        we;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dtc_bus_req_t;

  // controller states
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_MODE, ST_RD_SRC, ST_RD_DST, ST_RD_CNT,
    ST_DATA_RD, ST_DATA_WR, ST_WB_SRC, ST_WB_DST, ST_WB_CNT, ST_DONE
  } dtc_state_t;
endpackage : dtc_pkg

// *** core/dtc_addr_step.sv ***
`timescale 1ns/1ps
`include "dtc_defines.svh"
// next address after one transfer, for source or destination side
module dtc_addr_step
  import dtc_pkg::*;
(
  input  wire logic [15:0] addr,
  input  wire logic [1:0]  amode,
  input  wire logic        word,
  output logic [15:0]      next_addr
);
  logic [15:0] step; // 1 for byte, 2 for word
  always_comb
  begin
    step = word ? 16'h0002 : 16'h0001;
    if (!amode[1])
      next_addr = addr;           // fixed
    else if (!amode[0])
      next_addr = addr + step;    // increment
    else
      next_addr = addr - step;    // decrement
  end
endmodule : dtc_addr_step

// *** core/dtc_ctrl.sv ***
`timescale 1ns/1ps
`include "dtc_defines.svh"
// Function
// [R1] size bit selects byte or word transfer
// [R2] area-select picks destination or source repeat side
// [R3] mode field: normal, repeat, block; 11 unused
// [R4] destination address fixed, incremented or decremented
// [R5] source address fixed, incremented or decremented
// [R6] chain off: return idle after transfer
// [R7] chain select: always, or at count zero
// [R8] select zero: cpu irq only at count zero
// [R9] select one: cpu irq after every transfer
// [R10] descriptors fetched from fixed on-chip ram window
// [R11] descriptors not directly addressable registers
// [R12] software keeps on-chip ram enabled
// [R13] read source address, write destination address
// [R14] clear peripheral flag when select zero
// [R15] counter decrements per transfer or per block
// [R16] repeat end reloads count and area address
// [R17] software initialises descriptors before activation
module dtc_ctrl
  import dtc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        act_req,     // activation request pulse from interrupt controller
  input  wire logic [6:0]  act_vector,  // descriptor record number
  input  wire logic        onchip_ram_enable,
  output dtc_bus_req_t     bus_q,       // memory request
  input  wire logic        bus_ack,     // memory answer strobe
  input  wire logic [15:0] bus_rdata,
  output logic             busy_q,      // activation accepted and in progress
  output logic             cpu_irq_q,   // pass interrupt on to cpu, one-cycle pulse
  output logic             flag_clr_q   // clear requesting peripheral flag, one-cycle pulse
);
  dtc_state_t  st_q, st_d;
  logic [15:0] rec_q, rec_d;    // descriptor record base
  logic [7:0]  mra_q, mra_d;    // transfer_mode_descriptor_a copy
  logic [7:0]  mrb_q, mrb_d;    // transfer_mode_descriptor_b copy
  logic [15:0] sar_q, sar_d;    // source_addr_field copy
  logic [15:0] dar_q, dar_d;    // dest_addr_field copy
  logic [15:0] cnt_q, cnt_d;    // count word: a in normal, hi/lo in repeat/block
  logic [7:0]  blk_q, blk_d;    // units left in current block
  dtc_bus_req_t bus_d;
  logic busy_d, irq_d, clr_d;
  logic [15:0] sar_nx, dar_nx;
  logic        word, zero_now;
  logic [1:0]  md;

  assign word = mra_q[`DTC_SZ_BIT]; // [R1]
  assign md   = mra_q[`DTC_MD_LSB +: 2]; // [R3]

  // address steppers for each side
  dtc_addr_step u_src (.addr(sar_q), .amode(mra_q[`DTC_SM_LSB +: 2]), .word(word), .next_addr(sar_nx)); // [R5]
  dtc_addr_step u_dst (.addr(dar_q), .amode(mra_q[`DTC_DM_LSB +: 2]), .word(word), .next_addr(dar_nx)); // [R4]

  // next-state and datapath
  always_comb
  begin
    st_d = st_q; rec_d = rec_q; mra_d = mra_q; mrb_d = mrb_q;
    sar_d = sar_q; dar_d = dar_q; cnt_d = cnt_q; blk_d = blk_q;
    bus_d = bus_q; bus_d.req = 1'b0;
    busy_d = busy_q; irq_d = 1'b0; clr_d = 1'b0;
    zero_now = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        busy_d = 1'b0;
        // descriptors only live in on-chip ram; no new activation accepted while it is off
        if (act_req && onchip_ram_enable) // [R10] [R12]
        begin
          rec_d = `DTC_RAM_BASE + {6'h00, act_vector, 3'h0}; // [R10] [R11]
          busy_d = 1'b1;
          st_d = ST_RD_MODE;
          bus_d = '{req: 1'b1, we: 1'b0, word: 1'b1, addr: rec_d + `DTC_OFS_MODE, wdata: 16'h0000};
        end
      end
      ST_RD_MODE, ST_RD_SRC, ST_RD_DST, ST_RD_CNT:
      begin
        bus_d.req = !bus_ack;
        if (bus_ack)
        begin
          bus_d.req = 1'b1;
          case (st_q)
            ST_RD_MODE:
            begin
              mra_d = bus_rdata[15:8]; mrb_d = bus_rdata[7:0];
              st_d = ST_RD_SRC; bus_d.addr = rec_q + `DTC_OFS_SRC;
            end
            ST_RD_SRC:
            begin
              sar_d = bus_rdata; st_d = ST_RD_DST; bus_d.addr = rec_q + `DTC_OFS_DST;
            end
            ST_RD_DST:
            begin
              dar_d = bus_rdata; st_d = ST_RD_CNT; bus_d.addr = rec_q + `DTC_OFS_CNT;
            end
            default:
            begin
              cnt_d = bus_rdata;
              blk_d = bus_rdata[15:8];
              st_d = ST_DATA_RD;
              bus_d = '{req: 1'b1, we: 1'b0, word: word, addr: sar_q, wdata: 16'h0000}; // [R13]
            end
          endcase
        end
      end
      ST_DATA_RD:
      begin
        bus_d.req = !bus_ack;
        if (bus_ack)
        begin
          st_d = ST_DATA_WR;
          bus_d = '{req: 1'b1, we: 1'b1, word: word, addr: dar_q, wdata: bus_rdata}; // [R13]
        end
      end
      ST_DATA_WR:
      begin
        bus_d.req = !bus_ack;
        if (bus_ack)
        begin
          sar_d = sar_nx; // [R5]
          dar_d = dar_nx; // [R4]
          if (md == `DTC_MD_BLOCK && blk_q > 8'h01)
          begin
            // more units in this block: keep moving before counting
            blk_d = blk_q - 8'h01;
            st_d = ST_DATA_RD;
            bus_d = '{req: 1'b1, we: 1'b0, word: word, addr: sar_nx, wdata: 16'h0000};
          end
          else
          begin
            if (md == `DTC_MD_NORMAL)
              cnt_d = cnt_q - 16'h0001; // [R15]
            else
            begin
              // block and repeat: count low byte; restore the area-side address after each block or at repeat end
              cnt_d[7:0] = cnt_q[7:0] - 8'h01; // [R15]
              if (md == `DTC_MD_BLOCK || cnt_q[7:0] == 8'h01)
              begin
                if (md == `DTC_MD_REPEAT) cnt_d[7:0] = cnt_q[15:8]; // [R16]
                // back off by reload/block size units; the signed step undoes either direction
                if (!mra_q[`DTC_DTS_BIT]) // [R2]
                  dar_d = dar_nx - (dar_nx - dar_q) * 16'(cnt_q[15:8]); // [R16]
                else
                  sar_d = sar_nx - (sar_nx - sar_q) * 16'(cnt_q[15:8]); // [R16]
              end
            end
            st_d = ST_WB_SRC;
            bus_d = '{req: 1'b1, we: 1'b1, word: 1'b1, addr: rec_q + `DTC_OFS_SRC, wdata: sar_d};
          end
        end
      end
      ST_WB_SRC:
      begin
        bus_d.req = !bus_ack;
        if (bus_ack)
        begin
          st_d = ST_WB_DST;
          bus_d = '{req: 1'b1, we: 1'b1, word: 1'b1, addr: rec_q + `DTC_OFS_DST, wdata: dar_q};
        end
      end
      ST_WB_DST:
      begin
        bus_d.req = !bus_ack;
        if (bus_ack)
        begin
          st_d = ST_WB_CNT;
          bus_d = '{req: 1'b1, we: 1'b1, word: 1'b1, addr: rec_q + `DTC_OFS_CNT, wdata: cnt_q};
        end
      end
      ST_WB_CNT:
      begin
        bus_d.req = !bus_ack;
        if (bus_ack)
          st_d = ST_DONE;
      end
      ST_DONE:
      begin
        // counter zero in normal/block is full count reached; repeat never ends
        zero_now = (md == `DTC_MD_NORMAL) ? (cnt_q == 16'h0000) :
                   (md == `DTC_MD_BLOCK)  ? (cnt_q[7:0] == 8'h00) : 1'b0;
        if (mrb_q[`DTC_CHAIN_ENABLE_BIT] && (!mrb_q[`DTC_CHAIN_SELECT_BIT] || zero_now)) // [R7]
        begin
          rec_d = rec_q + `DTC_REC_BYTES;
          st_d = ST_RD_MODE;
          bus_d = '{req: 1'b1, we: 1'b0, word: 1'b1, addr: rec_d + `DTC_OFS_MODE, wdata: 16'h0000};
        end
        else
        begin
          irq_d = mrb_q[`DTC_CPU_IRQ_SELECT_BIT] || zero_now; // [R8] [R9]
          clr_d = !mrb_q[`DTC_CPU_IRQ_SELECT_BIT]; // [R14]
          busy_d = 1'b0;
          st_d = ST_IDLE; // [R6]
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE; rec_q <= 16'h0000; mra_q <= 8'h00; mrb_q <= 8'h00;
      sar_q <= 16'h0000; dar_q <= 16'h0000; cnt_q <= 16'h0000; blk_q <= 8'h00;
      bus_q <= '0; busy_q <= 1'b0; cpu_irq_q <= 1'b0; flag_clr_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d; rec_q <= rec_d; mra_q <= mra_d; mrb_q <= mrb_d;
      sar_q <= sar_d; dar_q <= dar_d; cnt_q <= cnt_d; blk_q <= blk_d;
      bus_q <= bus_d; busy_q <= busy_d; cpu_irq_q <= irq_d; flag_clr_q <= clr_d;
    end
  end

  // descriptor fetches fall inside the ram window unless a chain steps on past the last record
  property p_ram_window;
    @(posedge ref_clk) disable iff (rst)
    (bus_q.req && st_q inside {ST_RD_MODE, ST_RD_SRC, ST_RD_DST, ST_RD_CNT}) |->
      (bus_q.addr >= `DTC_RAM_BASE && bus_q.addr <= `DTC_RAM_LAST);
  endproperty
  a_ram_window: assert property (p_ram_window) else $error("descriptor fetch outside ram"); // [R10]

  // interrupt only at end, and only when allowed
  property p_irq_gate;
    @(posedge ref_clk) disable iff (rst)
    cpu_irq_q |-> $past(st_q) == ST_DONE && ($past(mrb_q[`DTC_CPU_IRQ_SELECT_BIT]) || $past(zero_now));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("cpu interrupt passed wrongly"); // [R8]

  property p_irq_all;
    @(posedge ref_clk) disable iff (rst)
    (st_q == ST_DONE && mrb_q[`DTC_CPU_IRQ_SELECT_BIT] && !mrb_q[`DTC_CHAIN_ENABLE_BIT]) |=> cpu_irq_q;
  endproperty
  a_irq_all: assert property (p_irq_all) else $error("cpu interrupt missing"); // [R9]

  property p_flag_clr;
    @(posedge ref_clk) disable iff (rst)
    flag_clr_q |-> !$past(mrb_q[`DTC_CPU_IRQ_SELECT_BIT]) && $past(st_q) == ST_DONE;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag clear wrong"); // [R14]

  property p_idle_after;
    @(posedge ref_clk) disable iff (rst)
    (st_q == ST_DONE && !mrb_q[`DTC_CHAIN_ENABLE_BIT]) |=> st_q == ST_IDLE;
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("no return to idle"); // [R6]

  property p_chain;
    @(posedge ref_clk) disable iff (rst)
    (st_q == ST_DONE && mrb_q[`DTC_CHAIN_ENABLE_BIT] && !mrb_q[`DTC_CHAIN_SELECT_BIT]) |=> st_q == ST_RD_MODE;
  endproperty
  a_chain: assert property (p_chain) else $error("chain not taken"); // [R7]

  property p_rd_src;
    @(posedge ref_clk) disable iff (rst)
    (st_q == ST_DATA_RD && bus_q.req) |-> (bus_q.addr == sar_q && !bus_q.we && bus_q.word == word);
  endproperty
  a_rd_src: assert property (p_rd_src) else $error("data read address wrong"); // [R13]

  property p_wr_dst;
    @(posedge ref_clk) disable iff (rst)
    (st_q == ST_DATA_WR && bus_q.req) |-> (bus_q.addr == dar_q && bus_q.we);
  endproperty
  a_wr_dst: assert property (p_wr_dst) else $error("data write address wrong"); // [R13]
endmodule : dtc_ctrl

// *** dv/dtc_mem_model.sv ***
`timescale 1ns/1ps
// memory behind the controller: byte store, slow or prompt one-cycle answers
module dtc_mem_model
  import dtc_pkg::*;
(
  input  wire logic         ref_clk,
  input  dtc_bus_req_t      bus_q,      // request from the controller
  input  wire logic [3:0]   wait_cyc,   // cycles held before each answer
  output logic              bus_ack,    // one-cycle answer strobe
  output logic [15:0]       bus_rdata   // read data, valid with the strobe only
);
  logic [7:0] mem [0:65535];  // high byte of a word at the lower address
  logic [3:0] cnt;            // wait cycles spent on the pending request
  initial
  begin
    bus_ack = 1'b0;
    bus_rdata = 16'h0000;
    cnt = 4'h0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // answer just after the edge; the strobe drops on the next edge, serving nothing, so a held req is not served twice
  always @(posedge ref_clk)
  begin
    #1;
    if (bus_ack)
    begin
      bus_ack = 1'b0;
      bus_rdata = ~bus_rdata;  // stale data must not look valid
    end
    else if (bus_q.req && cnt < wait_cyc)
      cnt = cnt + 4'h1;
    else if (bus_q.req)
    begin
      cnt = 4'h0;
      bus_ack = 1'b1;
      if (bus_q.we && bus_q.word)
        {mem[bus_q.addr], mem[bus_q.addr + 1]} = bus_q.wdata;
      else if (bus_q.we)
        mem[bus_q.addr] = bus_q.wdata[7:0];
      else if (bus_q.word)
        bus_rdata = {mem[bus_q.addr], mem[bus_q.addr + 1]};
      else
        bus_rdata = {~bus_rdata[15:8], mem[bus_q.addr]};  // upper byte is noise on byte reads
    end
  end
endmodule : dtc_mem_model

// *** dv/interrupt_driven_transfer_ctrl_test.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
// activates the controller and checks moved data, written-back records and end pulses
module interrupt_driven_transfer_ctrl_test import dtc_pkg::*;;
  logic         ref_clk, rst, act_req, onchip_ram_enable, bus_ack, busy_q, cpu_irq_q, flag_clr_q;
  logic [6:0]   act_vector;   // record number
  logic [15:0]  bus_rdata;
  logic [3:0]   wait_cyc;     // memory answer delay
  dtc_bus_req_t bus_q;
  int           failures = 0, tests_run = 0, cyc = 0;
  logic         irq_seen, clr_seen;  // end pulses caught in one activation
  dtc_ctrl uut (.ref_clk, .rst, .act_req, .act_vector, .onchip_ram_enable, .bus_q, .bus_ack, .bus_rdata,
    .busy_q, .cpu_irq_q, .flag_clr_q);
  dtc_mem_model u_mem (.ref_clk, .bus_q, .wait_cyc, .bus_ack, .bus_rdata);
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  function automatic logic [15:0] base(input logic [6:0] v);
    return 16'hebc0 + {6'h00, v, 3'h0};
  endfunction : base
  function automatic logic [15:0] rd16(input logic [15:0] a);
    return {u_mem.mem[a], u_mem.mem[a + 1]};
  endfunction : rd16
  task automatic put_rec(input logic [6:0] v, input logic [7:0] ma, mb, input logic [15:0] s, d, c);
    logic [15:0] b;
    b = base(v);
    {u_mem.mem[b], u_mem.mem[b+1], u_mem.mem[b+2], u_mem.mem[b+3]} = {ma, mb, s};
    {u_mem.mem[b+4], u_mem.mem[b+5], u_mem.mem[b+6], u_mem.mem[b+7]} = {d, c};
  endtask : put_rec
  task automatic chk_rec(input logic [6:0] v, input logic [15:0] s, d, c);
    `CHK("src wb", s, rd16(base(v) + 16'h2))
    `CHK("dst wb", d, rd16(base(v) + 16'h4))
    `CHK("cnt wb", c, rd16(base(v) + 16'h6))
  endtask : chk_rec
  // one activation pulse, then wait for the end under a bound
  task automatic go(input logic [6:0] v, input logic ei, ec);
    int n;
    act_vector = v;
    act_req = 1'b1;
    @(posedge ref_clk) #1;
    act_req = 1'b0;
    irq_seen = 1'b0;
    clr_seen = 1'b0;
    `CHK("first addr", base(v), bus_q.addr)
    for (n = 0; n < 400 && busy_q !== 1'b0; n++)
    begin
      @(posedge ref_clk) #1;
      if (cpu_irq_q === 1'b1) irq_seen = 1'b1;
      if (flag_clr_q === 1'b1) clr_seen = 1'b1;
    end
    `CHK("busy end", 1'b0, busy_q)
    `CHK("cpu irq", ei, irq_seen)
    `CHK("flag clr", ec, clr_seen)
  endtask : go
  task automatic t_byte_inc;
    put_rec(7'h00, 8'ha0, 8'h00, 16'h1000, 16'h2000, 16'h0002);
    u_mem.mem[16'h1000] = 8'ha5;
    go(7'h00, 1'b0, 1'b1);
    `CHK("byte", 8'ha5, u_mem.mem[16'h2000])
    chk_rec(7'h00, 16'h1001, 16'h2001, 16'h0001);
    $display("end t_byte_inc");
  endtask : t_byte_inc
  task automatic t_word_dec;  // slow memory, last transfer reaches zero
    wait_cyc = 4'h3;
    put_rec(7'h01, 8'hf1, 8'h00, 16'h1100, 16'h2100, 16'h0001);
    {u_mem.mem[16'h1100], u_mem.mem[16'h1101]} = 16'h1234;
    go(7'h01, 1'b1, 1'b1);
    `CHK("word", 16'h1234, rd16(16'h2100))
    chk_rec(7'h01, 16'h10fe, 16'h20fe, 16'h0000);
    wait_cyc = 4'h0;
    $display("end t_word_dec");
  endtask : t_word_dec
  task automatic t_fixed_irq;
    put_rec(7'h02, 8'h00, 8'h20, 16'h1200, 16'h2200, 16'h0005);
    u_mem.mem[16'h1200] = 8'h3c;
    go(7'h02, 1'b1, 1'b0);
    `CHK("fixed", 8'h3c, u_mem.mem[16'h2200])
    chk_rec(7'h02, 16'h1200, 16'h2200, 16'h0004);
    $display("end t_fixed_irq");
  endtask : t_fixed_irq
  task automatic t_repeat;  // destination is the repeat area, wraps on this transfer
    put_rec(7'h03, 8'ha4, 8'h00, 16'h1300, 16'h2301, 16'h0201);
    u_mem.mem[16'h1300] = 8'h77;
    go(7'h03, 1'b0, 1'b1);
    `CHK("repeat", 8'h77, u_mem.mem[16'h2301])
    chk_rec(7'h03, 16'h1301, 16'h2300, 16'h0202);
    $display("end t_repeat");
  endtask : t_repeat
  task automatic t_block;  // source is the block area, two-byte block
    put_rec(7'h04, 8'haa, 8'h00, 16'h1400, 16'h2400, 16'h0201);
    {u_mem.mem[16'h1400], u_mem.mem[16'h1401]} = 16'h1122;
    go(7'h04, 1'b1, 1'b1);
    `CHK("block", 16'h1122, rd16(16'h2400))
    chk_rec(7'h04, 16'h1400, 16'h2402, 16'h0200);
    $display("end t_block");
  endtask : t_block
  task automatic t_chain_all;
    put_rec(7'h05, 8'ha0, 8'h80, 16'h1500, 16'h2500, 16'h0003);
    put_rec(7'h06, 8'ha0, 8'h00, 16'h1600, 16'h2600, 16'h0001);
    {u_mem.mem[16'h1500], u_mem.mem[16'h1600]} = 16'h5a6b;
    go(7'h05, 1'b1, 1'b1);
    `CHK("chain", 16'h5a6b, {u_mem.mem[16'h2500], u_mem.mem[16'h2600]})
    $display("end t_chain_all");
  endtask : t_chain_all
  task automatic t_chain_zero;  // count stays nonzero, so no chain
    put_rec(7'h07, 8'ha0, 8'hc0, 16'h1700, 16'h2700, 16'h0003);
    put_rec(7'h08, 8'ha0, 8'h00, 16'h1800, 16'h2800, 16'h0001);
    {u_mem.mem[16'h1700], u_mem.mem[16'h1800]} = 16'h4499;
    go(7'h07, 1'b0, 1'b1);
    `CHK("no chain", 16'h4400, {u_mem.mem[16'h2700], u_mem.mem[16'h2800]})
    $display("end t_chain_zero");
  endtask : t_chain_zero
  task automatic t_ram_off;
    onchip_ram_enable = 1'b0;
    act_req = 1'b1;
    @(posedge ref_clk) #1;
    act_req = 1'b0;
    `CHK("busy off", 1'b0, busy_q)
    `CHK("req off", 1'b0, bus_q.req)
    onchip_ram_enable = 1'b1;
    // let one edge pass so the next activation does not re-drive act_req in this step
    @(posedge ref_clk) #1;
    $display("end t_ram_off");
  endtask : t_ram_off
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial
  begin
    rst = 1'b1;
    act_req = 1'b0;
    act_vector = 7'h00;
    onchip_ram_enable = 1'b1;
    wait_cyc = 4'h0;
    repeat (5) @(posedge ref_clk);
    #1 rst = 1'b0;
    t_ram_off();
    t_byte_inc();
    t_word_dec();
    t_fixed_irq();
    t_repeat();
    t_block();
    t_chain_all();
    t_chain_zero();
    print_verdict();
  end
endmodule : interrupt_driven_transfer_ctrl_test
